// File: logic/ramp_pkg.sv
/*
  Shared constants for the steering sensitivity and ramp limiter: register
  offsets, reset values, codes and timing. Assumes a 100 MHz APB clock.
*/
package ramp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SPEED_LIM = 8'h04;
  localparam logic [7:0] OFF_RATIO0 = 8'h08;
  localparam logic [7:0] OFF_RISE_T = 8'h20;
  localparam logic [7:0] OFF_FALL_T = 8'h24;
  localparam logic [7:0] OFF_FAST_T = 8'h28;
  localparam logic [7:0] OFF_ABORT_T = 8'h2C;
  localparam logic [7:0] OFF_RISE_TH = 8'h30;
  localparam logic [7:0] OFF_FALL_TH = 8'h34;
  localparam logic [7:0] OFF_RAMP_REGION = 8'h38;
  localparam logic [7:0] OFF_FAST_TH = 8'h3C;
  localparam logic [7:0] OFF_ABORT_TH = 8'h40;
  localparam logic [7:0] OFF_STATUS = 8'h44;
  localparam logic [7:0] OFF_SENS = 8'h48;
  // reset values
  localparam logic [1:0] RST_RAMP_SEL = 2'h0;
  localparam logic [1:0] RST_SENS_MODE = 2'h1;
  localparam logic [3:0] RST_SHAPE = 4'h0;
  localparam logic [10:0] RST_SPEED_LIM = 11'd500;
  localparam logic [10:0] RST_RATIO = 11'd400;
  localparam logic [10:0] RST_RISE_T = 11'd1;
  localparam logic [10:0] RST_FALL_T = 11'd350;
  localparam logic [10:0] RST_FAST_T = 11'd100;
  localparam logic [10:0] RST_ABORT_T = 11'd1;
  localparam logic [10:0] RST_REGION = 11'd500;
  localparam logic [10:0] RST_FAST_TH = 11'd1000;
  localparam logic [10:0] RST_ABORT_TH = 11'd0;
  // codes and limits
  localparam logic [1:0] SENS_SPEED = 2'h3;
  localparam logic [1:0] RAMP_OFF = 2'h0;
  localparam logic [1:0] RAMP_FIXED = 2'h1;
  localparam logic [1:0] RAMP_SPEED = 2'h2;
  localparam logic [10:0] FLOW_FULL = 11'd1000;
  localparam logic [10:0] TIME_MAX = 11'd1000;
  localparam logic [10:0] ABORT_OFF = 11'd1000;
  localparam logic [3:0] SHAPE_MAX = 4'hA;
  // one ramp step per millisecond tick
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
endpackage : ramp_pkg

// File: logic/steer_sensitivity_ramp_limiter.sv
/*
  Speed-dependent steering sensitivity and anti-jerk ramp limiter with an
  APB register slave. Assumes flow_request and vehicle_speed are already
  synchronous to pclk; flows are signed, 1000 = full flow.
*/
// Functional notes
// [R1] table points 2..5 sit at 1/8, 1/4, 1/2 and full speed limit
// [R2] speed limit accepts 1..1000, reset value 500
// [R3] software keeps ratios monotonic, 20..1200, default 400
// [R4] ratio 400 means 4.00 wheel turns end-lock to end-lock
// [R5] speed-dependent sensitivity only when mode selector is 3
// [R6] interpolate between adjacent points, speed magnitude used
// [R7] ramp acts on spool set-point, giving ramp-limited flow output
// [R8] ramp method 0 off, 1 fixed, 2 speed dependent; reset 0
// [R9] rise shape 0..10, default linear
// [R10] fall shape 0..10, default linear
// [R11] rise time 1..1000 ms, default 1, full span
// [R12] slow fall time 1..1000 ms, default 350
// [R13] fast fall above threshold; threshold 1000 disables it
// [R14] fast fall time is defined over the full span, default 100
// [R15] software keeps fast time below slow time and 150 ms
// [R16] reverse request past threshold aborts slow fall
// [R17] after abort use abort time, 1..1000 ms, default 1
// [R18] threshold 0 aborts on any reverse request
// [R19] threshold 1000 disables abort
// [R20] speed mode interpolates standstill and high-speed times
// [R21] ramp region 1..1000 in 0.1 km/h; high times apply there
// [R22] ramps off: output follows request every tick; the code copies it every pclk cycle
// [R23] step toward request limited by active ramp time per tick
`timescale 1ns/1ps
module steer_sensitivity_ramp_limiter #(
  parameter int TICK_CYC = ramp_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [11:0] flow_request,
  input wire logic signed [11:0] vehicle_speed,
  output logic signed [11:0] spool_setpoint,
  output logic [10:0] sensitivity
);
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RISE = 2'b01,
    ST_FALL = 2'b11, ST_ABORT = 2'b10} phase_e;

  logic [1:0] sens_mode_r, ramp_sel_r;
  logic [3:0] rise_shape_r, fall_shape_r;
  logic [10:0] speed_lim_r, rise_t_r, fall_t_r, fast_t_r, abort_t_r;
  logic [10:0] rise_th_r, fall_th_r, region_r, fast_fall_threshold_r;
  logic [10:0] fall_abort_threshold_r;
  logic [10:0] ratio_pt_r [6];
  logic [31:0] tick_cnt_r;
  logic tick;
  phase_e phase_r;

  // clamp a written value into lo..hi
  function automatic logic [10:0] clamp(input logic [31:0] v,
    input logic [10:0] lo, input logic [10:0] hi);
    if (v < 32'(lo)) clamp = lo;
    else if (v > 32'(hi)) clamp = hi;
    else clamp = v[10:0];
  endfunction : clamp

  // interpolate y0..y1 at position num/den, 0 <= num <= den
  function automatic logic [10:0] lerp(input logic [10:0] y0,
    input logic [10:0] y1, input logic [10:0] num, input logic [10:0] den);
    logic signed [23:0] d;
    d = 24'(signed'({1'b0, y1})) - 24'(signed'({1'b0, y0}));
    if (den == 11'd0) lerp = y1;
    else lerp = 11'(24'(signed'({1'b0, y0})) +
      (d * signed'({13'd0, num})) / signed'({13'd0, den}));
  endfunction : lerp

  //////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped addresses give pslverr
  logic wr_en;
  logic [10:0] wv;
  logic mapped;
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign wv = pwdata[10:0];
  assign mapped = (paddr <= ramp_pkg::OFF_SENS) && (paddr[1:0] == 2'b00);
  assign pslverr = psel && penable && !mapped;

  // control and timing registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sens_mode_r <= ramp_pkg::RST_SENS_MODE;
      ramp_sel_r <= ramp_pkg::RST_RAMP_SEL; // R8
      rise_shape_r <= ramp_pkg::RST_SHAPE; // R9
      fall_shape_r <= ramp_pkg::RST_SHAPE; // R10
      speed_lim_r <= ramp_pkg::RST_SPEED_LIM; // R2
      rise_t_r <= ramp_pkg::RST_RISE_T; // R11
      fall_t_r <= ramp_pkg::RST_FALL_T; // R12
      fast_t_r <= ramp_pkg::RST_FAST_T; // R14
      abort_t_r <= ramp_pkg::RST_ABORT_T; // R17
      rise_th_r <= ramp_pkg::RST_RISE_T;
      fall_th_r <= ramp_pkg::RST_FALL_T;
      region_r <= ramp_pkg::RST_REGION;
      fast_fall_threshold_r <= ramp_pkg::RST_FAST_TH;
      fall_abort_threshold_r <= ramp_pkg::RST_ABORT_TH;
    end else if (wr_en) begin
      case (paddr)
        ramp_pkg::OFF_CTRL: begin
          sens_mode_r <= pwdata[1:0];
          ramp_sel_r <= (pwdata[3:2] == 2'h3) ? ramp_pkg::RAMP_OFF :
            pwdata[3:2]; // R8
          rise_shape_r <= (pwdata[7:4] > ramp_pkg::SHAPE_MAX) ?
            ramp_pkg::SHAPE_MAX : pwdata[7:4]; // R9
          fall_shape_r <= (pwdata[11:8] > ramp_pkg::SHAPE_MAX) ?
            ramp_pkg::SHAPE_MAX : pwdata[11:8]; // R10
        end
        ramp_pkg::OFF_SPEED_LIM:
          speed_lim_r <= clamp(pwdata, 11'd1, ramp_pkg::TIME_MAX); // R2
        ramp_pkg::OFF_RISE_T:
          rise_t_r <= clamp(pwdata, 11'd1, ramp_pkg::TIME_MAX); // R11
        ramp_pkg::OFF_FALL_T:
          fall_t_r <= clamp(pwdata, 11'd1, ramp_pkg::TIME_MAX); // R12
        ramp_pkg::OFF_FAST_T:
          fast_t_r <= clamp(pwdata, 11'd1, ramp_pkg::TIME_MAX); // R14
        ramp_pkg::OFF_ABORT_T:
          abort_t_r <= clamp(pwdata, 11'd1, ramp_pkg::TIME_MAX); // R17
        ramp_pkg::OFF_RISE_TH:
          rise_th_r <= clamp(pwdata, 11'd1, ramp_pkg::TIME_MAX);
        ramp_pkg::OFF_FALL_TH:
          fall_th_r <= clamp(pwdata, 11'd1, ramp_pkg::TIME_MAX);
        ramp_pkg::OFF_RAMP_REGION:
          region_r <= clamp(pwdata, 11'd1, ramp_pkg::TIME_MAX); // R21
        ramp_pkg::OFF_FAST_TH:
          fast_fall_threshold_r <= clamp(pwdata, 11'd0,
            ramp_pkg::FLOW_FULL); // R13
        ramp_pkg::OFF_ABORT_TH:
          fall_abort_threshold_r <= (wv >= ramp_pkg::ABORT_OFF) ?
            ramp_pkg::ABORT_OFF : clamp(pwdata, 11'd0, 11'd500); // R16 R19
        default: ;
      endcase
    end
  end

  // ratio table; ordering is software's job, only range is forced
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_ratio
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ratio_pt_r[gi] <= ramp_pkg::RST_RATIO; // R3
        else if (wr_en && paddr == 8'(ramp_pkg::OFF_RATIO0 + 4 * gi))
          ratio_pt_r[gi] <= clamp(pwdata, 11'd20, 11'd1200); // R3
      end
    end
  endgenerate

  // read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr >= ramp_pkg::OFF_RATIO0 && paddr < ramp_pkg::OFF_RISE_T)
      prdata = {21'd0, ratio_pt_r[3'((paddr - ramp_pkg::OFF_RATIO0) >> 2)]};
    else case (paddr)
      ramp_pkg::OFF_CTRL: prdata = {20'd0, fall_shape_r, rise_shape_r,
        ramp_sel_r, sens_mode_r};
      ramp_pkg::OFF_SPEED_LIM: prdata = {21'd0, speed_lim_r};
      ramp_pkg::OFF_RISE_T: prdata = {21'd0, rise_t_r};
      ramp_pkg::OFF_FALL_T: prdata = {21'd0, fall_t_r};
      ramp_pkg::OFF_FAST_T: prdata = {21'd0, fast_t_r};
      ramp_pkg::OFF_ABORT_T: prdata = {21'd0, abort_t_r};
      ramp_pkg::OFF_RISE_TH: prdata = {21'd0, rise_th_r};
      ramp_pkg::OFF_FALL_TH: prdata = {21'd0, fall_th_r};
      ramp_pkg::OFF_RAMP_REGION: prdata = {21'd0, region_r};
      ramp_pkg::OFF_FAST_TH: prdata = {21'd0, fast_fall_threshold_r};
      ramp_pkg::OFF_ABORT_TH: prdata = {21'd0, fall_abort_threshold_r};
      ramp_pkg::OFF_STATUS: prdata = {18'd0, phase_r,
        spool_setpoint};
      ramp_pkg::OFF_SENS: prdata = {21'd0, sensitivity};
      default: prdata = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // sensitivity: speed magnitude against the breakpoint table
  logic [10:0] spd_abs, bp [6], sens_nxt;
  assign spd_abs = vehicle_speed[11] ? 11'(-vehicle_speed) :
    vehicle_speed[10:0]; // R6
  assign bp[0] = 11'd0;
  assign bp[1] = speed_lim_r >> 4;
  assign bp[2] = speed_lim_r >> 3; // R1
  assign bp[3] = speed_lim_r >> 2; // R1
  assign bp[4] = speed_lim_r >> 1; // R1
  assign bp[5] = speed_lim_r; // R1

  always_comb begin
    sens_nxt = ratio_pt_r[0];
    if (sens_mode_r == ramp_pkg::SENS_SPEED) begin // R5
      sens_nxt = ratio_pt_r[5];
      for (int k = 4; k >= 0; k--)
        if (spd_abs < bp[k+1])
          sens_nxt = lerp(ratio_pt_r[k], ratio_pt_r[k+1],
            spd_abs - bp[k], bp[k+1] - bp[k]); // R6
    end
  end

  // registered sensitivity in hundredths of wheel turns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sensitivity <= ramp_pkg::RST_RATIO;
    else sensitivity <= sens_nxt; // R4
  end

  //////////////////////////////////////////////////////////////////////////
  // millisecond update tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt_r <= 32'h0000_0000;
    else if (tick) tick_cnt_r <= 32'h0000_0000;
    else tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
  end
  assign tick = (tick_cnt_r >= 32'(TICK_CYC - 1));

  // active times: speed mode blends standstill and high-speed values
  logic [10:0] rise_eff, fall_eff, req_mag, out_mag, tgt_mag, step;
  logic [10:0] sp_cl;
  logic reverse, growing, in_fast, abort_hit;
  assign sp_cl = (spd_abs > region_r) ? region_r : spd_abs; // R21
  assign rise_eff = (ramp_sel_r == ramp_pkg::RAMP_SPEED) ?
    lerp(rise_t_r, rise_th_r, sp_cl, region_r) : rise_t_r; // R20
  assign fall_eff = (ramp_sel_r == ramp_pkg::RAMP_SPEED) ?
    lerp(fall_t_r, fall_th_r, sp_cl, region_r) : fall_t_r; // R20
  assign req_mag = flow_request[11] ? 11'(-flow_request) :
    flow_request[10:0];
  assign out_mag = spool_setpoint[11] ? 11'(-spool_setpoint) :
    spool_setpoint[10:0];
  assign reverse = (flow_request[11] != spool_setpoint[11]) &&
    (flow_request != 12'sd0) && (spool_setpoint != 12'sd0);
  assign tgt_mag = reverse ? 11'd0 : req_mag;
  assign growing = (tgt_mag > out_mag);
  assign in_fast = (out_mag > fast_fall_threshold_r); // R13
  // strictly beyond threshold, so 0 trips on any reverse request
  assign abort_hit = reverse && (req_mag > fall_abort_threshold_r) &&
    (fall_abort_threshold_r != ramp_pkg::ABORT_OFF); // R16 R18 R19

  // shape: steps below full flow cut by shape x 5%, full size from 1000 up
  function automatic logic [10:0] shaped(input logic [10:0] base,
    input logic [3:0] shp, input logic [10:0] mag);
    logic [21:0] t;
    t = 22'(base) * 22'(ramp_pkg::FLOW_FULL - 11'(shp) * 11'd50 +
      11'(shp) * 11'd50 * 11'(mag / 11'd1000));
    shaped = (t / 22'd1000 == 22'd0) ? 11'd1 : 11'(t / 22'd1000);
  endfunction : shaped

  // step per tick = full span / time; fast step spans whole range too
  always_comb begin
    step = 11'd1;
    if (growing)
      step = shaped(11'(ramp_pkg::FLOW_FULL / rise_eff), rise_shape_r,
        out_mag); // R11 R23
    else if (phase_r == ST_ABORT || abort_hit)
      step = 11'(ramp_pkg::FLOW_FULL / abort_t_r); // R17
    else if (in_fast)
      step = 11'(ramp_pkg::FLOW_FULL / fast_t_r); // R14
    else
      step = shaped(11'(ramp_pkg::FLOW_FULL / fall_eff), fall_shape_r,
        out_mag); // R12 R23
  end

  // ramp-limited set-point; clamp fast step at threshold boundary
  logic [10:0] mag_nxt;
  always_comb begin
    if (growing) mag_nxt = (tgt_mag - out_mag > step) ?
      out_mag + step : tgt_mag; // R23
    else begin
      mag_nxt = (out_mag - tgt_mag > step) ? out_mag - step : tgt_mag;
      if (in_fast && phase_r != ST_ABORT && !abort_hit &&
        mag_nxt < fast_fall_threshold_r && tgt_mag < fast_fall_threshold_r)
        mag_nxt = fast_fall_threshold_r; // R13
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spool_setpoint <= 12'sd0;
      phase_r <= ST_IDLE;
    end else if (ramp_sel_r == ramp_pkg::RAMP_OFF) begin
      spool_setpoint <= flow_request; // R22
      phase_r <= ST_IDLE;
    end else if (tick) begin
      spool_setpoint <= (reverse ? spool_setpoint[11] : flow_request[11])
        ? 12'(-signed'({1'b0, mag_nxt})) : signed'({1'b0, mag_nxt}); // R7
      case (phase_r)
        ST_IDLE, ST_RISE, ST_FALL:
          phase_r <= (mag_nxt == 11'd0) ? ST_IDLE :
            (abort_hit && !growing) ? ST_ABORT : // R16
            growing ? ST_RISE : ST_FALL;
        ST_ABORT: phase_r <= (mag_nxt == 11'd0) ? ST_IDLE : ST_ABORT; // R17
        default: phase_r <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  property p_ramp_off;
    @(posedge pclk) disable iff (!presetn)
      (ramp_sel_r == ramp_pkg::RAMP_OFF) ##1
      (ramp_sel_r == ramp_pkg::RAMP_OFF) |->
      spool_setpoint == $past(flow_request);
  endproperty
  a_ramp_off: assert property (p_ramp_off) // R22
    else $error("set-point not following request with ramps off");

  property p_hold_no_tick;
    @(posedge pclk) disable iff (!presetn)
      (ramp_sel_r != ramp_pkg::RAMP_OFF && !tick) ##1
      (ramp_sel_r != ramp_pkg::RAMP_OFF) |-> $stable(spool_setpoint);
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick) // R23
    else $error("set-point moved between ticks");

  property p_sens_fixed;
    @(posedge pclk) disable iff (!presetn)
      (sens_mode_r != ramp_pkg::SENS_SPEED) |=>
      sensitivity == $past(ratio_pt_r[0]);
  endproperty
  a_sens_fixed: assert property (p_sens_fixed) // R5
    else $error("sensitivity not point zero outside speed mode");

  property p_abort_phase;
    @(posedge pclk) disable iff (!presetn)
      (tick && ramp_sel_r != ramp_pkg::RAMP_OFF && abort_hit &&
       !growing && mag_nxt != 11'd0) |=> phase_r == ST_ABORT;
  endproperty
  a_abort_phase: assert property (p_abort_phase) // R16
    else $error("abort not entered on reverse request");

  property p_abort_off;
    @(posedge pclk) disable iff (!presetn)
      (fall_abort_threshold_r == ramp_pkg::ABORT_OFF) |-> !abort_hit;
  endproperty
  a_abort_off: assert property (p_abort_off) // R19
    else $error("abort fired while disabled");

  // after a ramp update the idle phase goes with a parked set-point
  property p_idle_zero;
    @(posedge pclk) disable iff (!presetn)
      (tick && ramp_sel_r != ramp_pkg::RAMP_OFF) ##1
      (ramp_sel_r != ramp_pkg::RAMP_OFF) |->
      ((phase_r == ST_IDLE) == (spool_setpoint == 12'sd0));
  endproperty
  a_idle_zero: assert property (p_idle_zero) // R7
    else $error("phase idle does not match a zero set-point");
endmodule : steer_sensitivity_ramp_limiter

// File: testbench/valve_partner.sv
/*
  Far side model: the steering wheel that makes the flow request and speed,
  and the valve spool that records the largest set-point step it was asked
  to follow. Assumes one pclk domain and the bench's commanded values.
*/
`timescale 1ns/1ps
module valve_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic signed [11:0] cmd_flow,
  input wire logic signed [11:0] cmd_speed,
  input wire logic signed [11:0] spool_setpoint,
  output logic signed [11:0] flow_request,
  output logic signed [11:0] vehicle_speed,
  output logic [11:0] max_step
);
  logic signed [11:0] last_r;
  logic signed [12:0] d;
  assign d = 13'(spool_setpoint) - 13'(last_r);
  ////////////////////////////////////////////////////////////////////////////
  // wheel side changes just after the edge, never mid-cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_request <= 12'sh000;
      vehicle_speed <= 12'sh000;
    end else begin
      flow_request <= cmd_flow;
      vehicle_speed <= cmd_speed;
    end
  end
  // spool side: a jerk shows as a large step between cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= 12'sh000;
      max_step <= 12'h000;
    end else begin
      last_r <= spool_setpoint;
      if (clr) begin
        max_step <= 12'h000;
      end else if (12'(d < 0 ? -d : d) > max_step) begin
        max_step <= 12'(d < 0 ? -d : d);
      end
    end
  end
endmodule : valve_partner

// File: testbench/tb_steer_sensitivity_ramp_limiter.sv
/*
  Self-checking bench for the sensitivity and ramp limiter. Assumes the APB
  slave answers by pready and a shortened tick of TICK cycles.
*/
`timescale 1ns/1ps
module tb_steer_sensitivity_ramp_limiter;
  localparam int TICK = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, clr = 1'b0;
  logic signed [11:0] cmd_flow = 12'sh000, cmd_speed = 12'sh000;
  logic signed [11:0] flow_request, vehicle_speed, spool_setpoint;
  logic [10:0] sensitivity;
  logic [11:0] max_step;
  int err_count = 0;
  int n_tests = 0;
  steer_sensitivity_ramp_limiter #(.TICK_CYC(TICK))
    steer_sensitivity_ramp_limiter_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flow_request(flow_request), .vehicle_speed(vehicle_speed),
    .spool_setpoint(spool_setpoint), .sensitivity(sensitivity));
  valve_partner valve_partner_inst (.pclk(pclk), .presetn(presetn),
    .clr(clr), .cmd_flow(cmd_flow), .cmd_speed(cmd_speed),
    .spool_setpoint(spool_setpoint), .flow_request(flow_request),
    .vehicle_speed(vehicle_speed), .max_step(max_step));
  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  // one apb transfer; idle edge first so back-to-back never races
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) err_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic chk(input string s, input logic [31:0] x,
                     input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", s, x, g);
    end
  endtask : chk
  // window check: tick phase is unknown, so allow one tick either way
  task automatic rng(input string s, input logic signed [11:0] lo,
                     input logic signed [11:0] hi,
                     input logic signed [11:0] g);
    n_tests++;
    if (((g >= lo) && (g <= hi)) !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", s, lo, hi, g);
    end
  endtask : rng
  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge pclk);
  endtask : ticks
  // ramps off and request zero: set-point parks at zero
  task automatic park(input logic [31:0] ctrl);
    wr(ramp_pkg::OFF_CTRL, 32'h1);
    cmd_flow <= 12'sh000;
    repeat (4) @(posedge pclk);
    wr(ramp_pkg::OFF_CTRL, ctrl);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
  endtask : park
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] a[11] = '{ramp_pkg::OFF_CTRL, ramp_pkg::OFF_SPEED_LIM,
      ramp_pkg::OFF_RISE_T, ramp_pkg::OFF_FALL_T, ramp_pkg::OFF_FAST_T,
      ramp_pkg::OFF_ABORT_T, ramp_pkg::OFF_RISE_TH, ramp_pkg::OFF_FALL_TH,
      ramp_pkg::OFF_RAMP_REGION, ramp_pkg::OFF_FAST_TH,
      ramp_pkg::OFF_ABORT_TH};
    logic [31:0] x[11] = '{32'h1, 32'h1F4, 32'h1, 32'h15E, 32'h64, 32'h1,
      32'h1, 32'h15E, 32'h1F4, 32'h3E8, 32'h0};
    logic [31:0] q;
    logic e;
    chk("sens_rst", 32'h190, {21'h0, sensitivity});
    for (int i = 0; i < 11; i++) begin
      xfer(1'b0, a[i], 32'h0, q, e);
      chk("reg_rst", x[i], q);
    end
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, 8'(ramp_pkg::OFF_RATIO0 + 4 * i), 32'h0, q, e);
      chk("ratio_rst", 32'h190, q);
    end
    xfer(1'b0, 8'h4C, 32'h0, q, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
  endtask : t_reset
  // ramps off: output is the request, both signs
  task automatic t_off;
    cmd_flow <= 12'sh12C;
    repeat (3) @(posedge pclk);
    rng("off_pos", 12'sh12C, 12'sh12C, spool_setpoint);
    cmd_flow <= -12'sh3E8;
    repeat (3) @(posedge pclk);
    rng("off_neg", -12'sh3E8, -12'sh3E8, spool_setpoint);
  endtask : t_off
  // speed table: limit 800 puts points at 0,50,100,200,400,800
  task automatic t_sens;
    logic signed [11:0] v[7] = '{12'sh000, 12'sh032, 12'sh064, 12'sh0C8,
      12'sh12C, -12'sh12C, 12'sh320};
    logic [31:0] x[7] = '{32'h64, 32'hC8, 32'h12C, 32'h190, 32'h1C2,
      32'h1C2, 32'h258};
    for (int i = 0; i < 6; i++) begin
      wr(8'(ramp_pkg::OFF_RATIO0 + 4 * i), 32'(100 * (i + 1)));
    end
    wr(ramp_pkg::OFF_SPEED_LIM, 32'h320);
    cmd_speed <= 12'sh12C;
    repeat (4) @(posedge pclk);
    chk("sens_fixed", 32'h64, {21'h0, sensitivity});
    wr(ramp_pkg::OFF_CTRL, 32'h3);
    for (int i = 0; i < 7; i++) begin
      cmd_speed <= v[i];
      repeat (4) @(posedge pclk);
      chk("sens_speed", x[i], {21'h0, sensitivity});
    end
    cmd_speed <= 12'sh000;
  endtask : t_sens
  // rise 10 ms, step 100 a tick
  task automatic t_rise;
    wr(ramp_pkg::OFF_RISE_T, 32'hA);
    park(32'h5);
    cmd_flow <= 12'sh3E8;
    ticks(4);
    rng("rise_mid", 12'sh12C, 12'sh1F4, spool_setpoint);
    ticks(8);
    rng("rise_end", 12'sh3E8, 12'sh3E8, spool_setpoint);
    chk("rise_step", 32'h64, 32'(max_step > 12'h064 ? 12'h0 : 12'h064));
  endtask : t_rise
  // fast 100/tick down to 500, then slow 50/tick
  task automatic t_fall;
    wr(ramp_pkg::OFF_FALL_T, 32'h14);
    wr(ramp_pkg::OFF_FAST_T, 32'hA);
    wr(ramp_pkg::OFF_FAST_TH, 32'h1F4);
    cmd_flow <= 12'sh000;
    ticks(6);
    rng("fall_fast", 12'sh190, 12'sh1F4, spool_setpoint);
    ticks(12);
    rng("fall_end", 12'sh000, 12'sh000, spool_setpoint);
    wr(ramp_pkg::OFF_FAST_TH, 32'h3E8);
  endtask : t_fall
  // reverse request during slow fall, abort off then on
  task automatic t_abort;
    wr(ramp_pkg::OFF_ABORT_TH, 32'h3E8);
    wr(ramp_pkg::OFF_ABORT_T, 32'h5);
    cmd_flow <= 12'sh3E8;
    ticks(12);
    cmd_flow <= -12'sh064;
    ticks(4);
    rng("abort_off", 12'sh2EE, 12'sh352, spool_setpoint);
    wr(ramp_pkg::OFF_ABORT_TH, 32'h0);
    cmd_flow <= 12'sh3E8;
    ticks(12);
    cmd_flow <= -12'sh064;
    ticks(3);
    rng("abort_on", 12'sh0C8, 12'sh258, spool_setpoint);
    ticks(10);
    rng("abort_end", -12'sh064, -12'sh064, spool_setpoint);
  endtask : t_abort
  // speed ramps: at the region edge the high-speed time rules
  task automatic t_speed;
    wr(ramp_pkg::OFF_RISE_TH, 32'h32);
    wr(ramp_pkg::OFF_RAMP_REGION, 32'h64);
    park(32'h9);
    cmd_speed <= -12'sh064;
    cmd_flow <= 12'sh3E8;
    ticks(5);
    rng("speed_rise", 12'sh050, 12'sh078, spool_setpoint);
  endtask : t_speed
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_off();
    t_sens();
    t_rise();
    t_fall();
    t_abort();
    t_speed();
    end_sim();
  end
  // watchdog: the run needs under a thousand cycles
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
endmodule : tb_steer_sensitivity_ramp_limiter
